/* logic/eepc_top.sv */
// eepc_top: eeprom program/erase control with axi4-lite register access
`timescale 1ns/1ps

// Function
// RULE1: writes to eeprom addresses are ignored while high voltage command is set.
// RULE2: while an operation is latched, writes to other eeprom locations are blocked.
// RULE3: odd and even row bits together program every row of that half.
// RULE4: control bit 5 has no storage and reads zero.
// RULE5: erase scope: bulk, 16-byte row, or single byte from byte/row bits.
// RULE6: erase mode bit selects erase; clear means read or program.
// RULE7: latch control set captures write targets; clear reads array like rom.
// RULE8: block protect never affects reads, only programming and erasing.
// RULE9: high voltage command bit switches the charge pump on or off.
// RULE10: programming ignores the byte and row select bits.
// RULE11: software sets oscillator select when bus clock is 1MHz or slower.
// RULE12: software erases before programming; programming only clears bits.
// RULE13: software erase order: setup, target write, voltage on, 10 ms, off, clear.
// RULE14: written address selects target; any location in row or array suffices.
// RULE15: software program order: latch, store, voltage on, 10 ms, clear.
// RULE16: configuration cell programs and erases like eeprom unless its protect is set; the code ignores the protect in special mode.
// RULE17: configuration bits 6 and 5 always read as ones.
// RULE18: configuration reads come from latches; programming goes to the cell.
// RULE19: configuration latches load from the cell only during reset.
// RULE20: in special mode configuration latches are directly writable.
// RULE21: secured bootstrap: send ones, unprotect, erase and verify, fill ram, erase config.
// RULE22: security disable clear enables security, forcing single-chip operation.
// RULE23: each set block protect bit blocks writing its eeprom block.
// RULE24: an erased byte reads all ones.
// RULE25: the high voltage stays on until software clears the command bit.
module eepc_top
    import eepc_pkg::*;
#(
    parameter int ADDR_W = 13
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic special_mode_indicator,
    input wire logic bootstrap_mode,
    input wire logic ram_fill_done,
    output logic charge_pump_on,
    output logic internal_osc_select,
    output logic [7:0] system_config,
    output logic single_chip_only,
    output logic serial_ones_req,
    output logic ram_fill_req
);
    // ----------------
    // address decode
    // ----------------
    function automatic eepc_kind_type addr_kind(input logic [ADDR_W-1:0] a);
        eepc_kind_type k;
        k = K_NONE;
        if (a[1:0] != 2'b00)
            k = K_NONE;
        else if (a >= EE_BASE && a < EE_BASE + 13'(EE_BYTES * 4))
            k = K_EE;
        else if (a == {IDX_PROG_CTRL, 2'b00})
            k = K_CTRL;
        else if (a == {IDX_SYS_CFG, 2'b00})
            k = K_CFG;
        else if (a == {IDX_BLK_PROT, 2'b00})
            k = K_BLOCK_PROTECT_REGISTER;
        else if (a == {IDX_OPTION, 2'b00})
            k = K_OPT;
        return k;
    endfunction : addr_kind
    function automatic logic [9:0] ee_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - EE_BASE;
        return off[11:2];
    endfunction : ee_index
    // block protect lookup for one array byte
    function automatic logic is_protected(input int i, input logic [7:0] bp);
        logic p;
        if (i <= BLK_LAST0)
            p = bp[0];
        else if (i <= BLK_LAST1)
            p = bp[1];
        else if (i <= BLK_LAST2)
            p = bp[2];
        else if (i <= BLK_LAST3)
            p = bp[3];
        else
            p = bp[4];
        return p;
    endfunction : is_protected
    // ----------------
    // state
    // ----------------
    logic [7:0] cells [EE_BYTES];
    logic [7:0] cfg_cell_ff;
    eepc_cfg_type cfg_latch_ff;
    eepc_ctrl_type ctrl_ff;
    logic [7:0] block_protect_register_ff;
    logic osc_sel_ff;
    logic hv_prev_ff;
    logic lat_valid_ff;
    logic lat_cfg_ff;
    logic [9:0] lat_idx_ff;
    logic [7:0] lat_data_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic [7:0] w_data_ff;
    logic w_strb_ff;
    typedef enum {S_RESET, S_IDLE, S_SERIAL, S_PROT, S_ERASE, S_VERIFY, S_RAM, S_CFG} eepc_sec_type;
    eepc_sec_type sec_ff;
    // ----------------
    // write path decode
    // ----------------
    logic do_wr;
    eepc_kind_type wr_kind;
    logic [9:0] wr_idx;
    logic ee_wr;
    logic fire;
    logic sec_erase;
    logic all_erased;
    eepc_ctrl_type new_ctrl;
    assign do_wr = aw_got_ff && w_got_ff && !s_axi_bvalid && w_strb_ff;
    assign wr_kind = addr_kind(aw_addr_ff);
    assign wr_idx = ee_index(aw_addr_ff);
    assign new_ctrl = eepc_ctrl_type'(w_data_ff & PROG_CTRL_MASK);  // [RULE4]
    // array or config cell write while latch control set captures a target
    assign ee_wr = do_wr && ctrl_ff.latch_control && (wr_kind == K_EE || wr_kind == K_CFG); // [RULE7]
    // operation happens once, at the rising of the command with a latched target
    assign fire = ctrl_ff.high_voltage_command && !hv_prev_ff && ctrl_ff.latch_control && lat_valid_ff;
    assign sec_erase = (sec_ff == S_ERASE) && cfg_latch_ff.eeprom_enable;
    // verify scan for the secured bootstrap sequence
    always_comb
    begin
        all_erased = 1'b1;
        for (int i = 0; i < EE_BYTES; i++)
            if (cells[i] != ERASED)
                all_erased = 1'b0;
    end

    // ----------------
    // axi4-lite write channel
    // ----------------
    // address and data are taken in either order; response after both
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_data_ff <= 8'h00;
            w_strb_ff <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_got_ff && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_got_ff && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_ff <= 1'b1;
                w_data_ff <= s_axi_wdata[7:0];
                w_strb_ff <= s_axi_wstrb[0];
            end
            if (aw_got_ff && w_got_ff && !s_axi_bvalid)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (addr_kind(aw_addr_ff) == K_NONE) ? RESP_DECERR : RESP_OKAY;
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------
    // axi4-lite read channel
    // ----------------
    // one read at a time; data answers the cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                s_axi_rdata <= 32'h0000_0000;
                unique case (addr_kind(s_axi_araddr))
                    K_CTRL: s_axi_rdata[7:0] <= ctrl_ff & PROG_CTRL_MASK;  // [RULE4]
                    K_CFG: s_axi_rdata[7:0] <= cfg_latch_ff | CFG_ONES;  // [RULE17] [RULE18]
                    K_BLOCK_PROTECT_REGISTER: s_axi_rdata[7:0] <= block_protect_register_ff;
                    K_OPT: s_axi_rdata[OSC_SEL_BIT] <= osc_sel_ff;
                    // with latch control clear the array reads like rom, protect ignored
                    K_EE: s_axi_rdata[7:0] <= ctrl_ff.latch_control ? 8'h00 : cells[ee_index(s_axi_araddr)]; // [RULE7] [RULE8]
                    K_NONE: s_axi_rresp <= RESP_DECERR;
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------
    // control, block protect and option registers
    // ----------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_ff <= eepc_ctrl_type'(PROG_CTRL_RST);
            hv_prev_ff <= 1'b0;
            osc_sel_ff <= 1'b0;
        end
        else
        begin
            hv_prev_ff <= ctrl_ff.high_voltage_command;
            // the pulse is not timed here; voltage stays until software clears it
            if (do_wr && wr_kind == K_CTRL)
                ctrl_ff <= new_ctrl;  // [RULE9] [RULE25]
            if (do_wr && wr_kind == K_OPT)
                osc_sel_ff <= w_data_ff[OSC_SEL_BIT];  // [RULE11]
        end
    end

    // bootstrap clears protection; software may set it again afterwards
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            block_protect_register_ff <= BLK_PROT_RST;
        else if (sec_ff == S_PROT)
            block_protect_register_ff <= 8'h00;  // [RULE21]
        else if (do_wr && wr_kind == K_BLOCK_PROTECT_REGISTER)
            block_protect_register_ff <= w_data_ff & BLK_PROT_MASK;
    end
    // ----------------
    // target latch
    // ----------------
    // while high voltage is on every array write is dropped; while a target is held
    // only the same location may refresh the data
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !ctrl_ff.latch_control)
        begin
            lat_valid_ff <= 1'b0;
            lat_cfg_ff <= 1'b0;
            lat_idx_ff <= 10'h000;
            lat_data_ff <= 8'h00;
        end
        else if (ee_wr && !ctrl_ff.high_voltage_command)  // [RULE1]
        begin
            if (!lat_valid_ff || (lat_cfg_ff == (wr_kind == K_CFG) && (wr_kind == K_CFG || lat_idx_ff == wr_idx)))
            begin
                lat_valid_ff <= 1'b1;  // [RULE2]
                lat_cfg_ff <= (wr_kind == K_CFG);
                lat_idx_ff <= (wr_kind == K_EE) ? wr_idx : 10'h000;  // [RULE14]
                lat_data_ff <= w_data_ff;
            end
        end
    end

    // ----------------
    // array cells: program clears bits, erase sets bytes to all ones
    // ----------------
    generate
        for (genvar g = 0; g < EE_BYTES; g++)
        begin : g_cell
            logic tgt;
            logic same_half;
            logic row_odd;
            always_comb
            begin
                same_half = (g >= HALF_BYTES) == (int'(lat_idx_ff) >= HALF_BYTES);
                row_odd = ((g / ROW_BYTES) % 2) == 1;
                if (ctrl_ff.erase_mode)
                begin
                    if (ctrl_ff.byte_sel)
                        tgt = (g == int'(lat_idx_ff));  // [RULE5]
                    else if (ctrl_ff.row_sel)
                        tgt = (g / ROW_BYTES) == (int'(lat_idx_ff) / ROW_BYTES);  // [RULE5] [RULE14]
                    else
                        tgt = 1'b1;  // [RULE5]
                end
                else if (ctrl_ff.odd_rows || ctrl_ff.even_rows)
                    tgt = same_half && ((g % ROW_BYTES) == (int'(lat_idx_ff) % ROW_BYTES))
                        && ((row_odd && ctrl_ff.odd_rows) || (!row_odd && ctrl_ff.even_rows));  // [RULE3]
                else
                    tgt = (g == int'(lat_idx_ff));  // [RULE10]
            end
            always_ff @(posedge aclk)
            begin
                if (sec_erase)
                    cells[g] <= ERASED;  // [RULE21] [RULE24]
                else if (fire && !lat_cfg_ff && tgt && !is_protected(g, block_protect_register_ff))  // [RULE23] [RULE8]
                    cells[g] <= ctrl_ff.erase_mode ? ERASED : (cells[g] & lat_data_ff);  // [RULE6] [RULE24]
            end
        end
    endgenerate
    // configuration cell, reached through the normal sequence at its own address
    always_ff @(posedge aclk)
    begin
        if (sec_ff == S_CFG)
            cfg_cell_ff <= ERASED;  // [RULE21]
        else if (fire && lat_cfg_ff && (!block_protect_register_ff[CFG_PROT_BIT] || special_mode_indicator))
            cfg_cell_ff <= ctrl_ff.erase_mode ? ERASED : (cfg_cell_ff & lat_data_ff);  // [RULE16] [RULE18]
    end

    // ----------------
    // configuration working latches
    // ----------------
    // loaded from the cell only in reset; a new cell value waits for the next reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cfg_latch_ff <= eepc_cfg_type'(cfg_cell_ff | CFG_ONES);  // [RULE19]
        else if (do_wr && wr_kind == K_CFG && special_mode_indicator && !ctrl_ff.latch_control)
            cfg_latch_ff <= eepc_cfg_type'(w_data_ff | CFG_ONES);  // [RULE20]
    end

    // ----------------
    // secured bootstrap sequence
    // ----------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sec_ff <= S_RESET;
        else
        begin
            unique case (sec_ff)
                S_RESET: sec_ff <= (!cfg_latch_ff.security_disable && bootstrap_mode) ? S_SERIAL : S_IDLE;
                S_IDLE: sec_ff <= S_IDLE;
                S_SERIAL: sec_ff <= S_PROT;
                S_PROT: sec_ff <= S_ERASE;
                S_ERASE: sec_ff <= S_VERIFY;
                // a failed verify starts the whole sequence again
                S_VERIFY: sec_ff <= (all_erased || !cfg_latch_ff.eeprom_enable) ? S_RAM : S_SERIAL;  // [RULE21]
                S_RAM: sec_ff <= ram_fill_done ? S_CFG : S_RAM;
                S_CFG: sec_ff <= S_IDLE;
            endcase
        end
    end

    // ----------------
    // registered outputs
    // ----------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            charge_pump_on <= 1'b0;
            internal_osc_select <= 1'b0;
            system_config <= CFG_ONES;
            single_chip_only <= 1'b0;
            serial_ones_req <= 1'b0;
            ram_fill_req <= 1'b0;
        end
        else
        begin
            charge_pump_on <= ctrl_ff.high_voltage_command;  // [RULE9]
            internal_osc_select <= osc_sel_ff;
            system_config <= cfg_latch_ff | CFG_ONES;  // [RULE18]
            single_chip_only <= !cfg_latch_ff.security_disable;  // [RULE22]
            serial_ones_req <= (sec_ff == S_SERIAL);  // [RULE21]
            ram_fill_req <= (sec_ff == S_RAM) && !ram_fill_done;
        end
    end
endmodule : eepc_top

/* logic/eepc_pkg.sv */
// eepc_pkg: constants and types for the eeprom program/erase control block
package eepc_pkg;
    // ----------------
    // register indices (byte address is four times the index)
    // ----------------
    localparam logic [7:0] IDX_PROG_CTRL = 8'h3b;
    localparam logic [7:0] IDX_SYS_CFG = 8'h3f;
    localparam logic [7:0] IDX_BLK_PROT = 8'h35;
    localparam logic [7:0] IDX_OPTION = 8'h39;
    localparam logic [12:0] EE_BASE = 13'h1000;
    // ----------------
    // array geometry
    // ----------------
    localparam int EE_BYTES = 640;
    localparam int ROW_BYTES = 16;
    localparam int HALF_BYTES = 320;
    localparam int BLK_LAST0 = 31;
    localparam int BLK_LAST1 = 95;
    localparam int BLK_LAST2 = 223;
    localparam int BLK_LAST3 = 511;
    // ----------------
    // reset values and fixed bits
    // ----------------
    localparam logic [7:0] PROG_CTRL_RST = 8'h00;
    localparam logic [7:0] PROG_CTRL_MASK = 8'hdf;
    localparam logic [7:0] BLK_PROT_RST = 8'h3f;
    localparam logic [7:0] BLK_PROT_MASK = 8'h3f;
    localparam logic [7:0] OPTION_MASK = 8'h40;
    localparam int OSC_SEL_BIT = 6;
    localparam int CFG_PROT_BIT = 5;
    localparam logic [7:0] CFG_ONES = 8'h60;
    localparam logic [7:0] ERASED = 8'hff;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // program control register layout, bit 7 first
    typedef struct packed {
        logic odd_rows;
        logic even_rows;
        logic unused;
        logic byte_sel;
        logic row_sel;
        logic erase_mode;
        logic latch_control;
        logic high_voltage_command;
    } eepc_ctrl_type;

    // system configuration layout, bit 7 first
    typedef struct packed {
        logic rom_map_select;
        logic one6;
        logic one5;
        logic pullup_assign_enable;
        logic security_disable;
        logic watchdog_disable;
        logic rom_enable;
        logic eeprom_enable;
    } eepc_cfg_type;

    typedef enum logic [2:0] {K_CTRL, K_CFG, K_BLOCK_PROTECT_REGISTER, K_OPT, K_EE, K_NONE} eepc_kind_type;
endpackage : eepc_pkg

/* dv/eepc_props.sv */
// eepc_props: port-level assertions for the eeprom program/erase control block
`timescale 1ns/1ps
module eepc_props
    import eepc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic special_mode_indicator,
    input wire logic ram_fill_done,
    input wire logic charge_pump_on,
    input wire logic [7:0] system_config,
    input wire logic single_chip_only,
    input wire logic serial_ones_req,
    input wire logic ram_fill_req
);
    // ----------------
    // properties, one clock domain
    // ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    cfg_ones_a: assert property (system_config[6:5] == 2'b11)
        else $error("config bits 6 and 5 not ones");
    pin_follow_a: assert property ($past(aresetn) && $stable(system_config[3]) |-> single_chip_only == !system_config[3])
        else $error("single chip disagrees");
    // the output takes the reset-loaded latches one edge after release, so skip two edges
    cfg_hold_a: assert property (!special_mode_indicator && !$past(special_mode_indicator) && $past(aresetn, 2) |-> $stable(system_config))
        else $error("config moved outside reset");
    pump_on_a: assert property ($rose(charge_pump_on) |-> $past(s_axi_bvalid))
        else $error("pump rose unasked");
    pump_hold_a: assert property ($fell(charge_pump_on) |-> $past(s_axi_bvalid))
        else $error("pump dropped unasked");
    ones_pulse_a: assert property (serial_ones_req |=> !serial_ones_req)
        else $error("ones request longer than one cycle");
    fill_end_a: assert property (ram_fill_req && ram_fill_done |-> ##[1:2] !ram_fill_req)
        else $error("ram fill request not withdrawn");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    ready_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel open while response pending");
    read_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");

    cover property ($rose(charge_pump_on));
    cover property (serial_ones_req);
    cover property (s_axi_bvalid && s_axi_bresp == RESP_DECERR);
    cover property (ram_fill_req && ram_fill_done);
endmodule : eepc_props

/* dv/eepc_partner.sv */
// eepc_partner: far-side model answering the ram fill request
`timescale 1ns/1ps
module eepc_partner
    import eepc_pkg::*;
#(
    parameter int DELAY = 4
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ram_fill_req,
    output logic ram_fill_done
);
    int cnt_ff;

    // ram fills DELAY+1 cycles after the request; done holds until the request drops so no edge is missed
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !ram_fill_req)
        begin
            cnt_ff <= 0;
            ram_fill_done <= 1'b0;
        end
        else if (cnt_ff == DELAY)
            ram_fill_done <= 1'b1;
        else
            cnt_ff <= cnt_ff + 1;
    end
endmodule : eepc_partner

/* dv/eepc_top_test.sv */
// eepc_top_test: register-level testbench for the eeprom program/erase control block
`timescale 1ns/1ps
module eepc_top_test
    import eepc_pkg::*;
();
    localparam logic [12:0] A_CTRL = {3'h0, IDX_PROG_CTRL, 2'b00};
    localparam logic [12:0] A_CFG = {3'h0, IDX_SYS_CFG, 2'b00};
    localparam logic [12:0] A_BP = {3'h0, IDX_BLK_PROT, 2'b00};
    localparam logic [12:0] A_OPT = {3'h0, IDX_OPTION, 2'b00};
    localparam logic [12:0] A_BAD = 13'h0100;
    logic aclk = 1'b0, aresetn = 1'b0, special_mode_indicator = 1'b0, bootstrap_mode = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [12:0] s_axi_awaddr = 13'h0, s_axi_araddr = 13'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ram_fill_done;
    logic charge_pump_on, internal_osc_select, single_chip_only, serial_ones_req, ram_fill_req;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] system_config;
    int num_errors = 0, checked = 0, w;

    eepc_top #(.ADDR_W(13)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .special_mode_indicator, .bootstrap_mode, .ram_fill_done, .charge_pump_on, .internal_osc_select,
        .system_config, .single_chip_only, .serial_ones_req, .ram_fill_req);
    // slow answer on purpose, so the fill request has to stand a while
    eepc_partner #(.DELAY(6)) far_u (.aclk, .aresetn, .ram_fill_req, .ram_fill_done);

    // 50 MHz bus clock
    initial forever #10 aclk = ~aclk;

    // ----------------
    // helpers
    // ----------------
    function automatic logic [12:0] arr(input int i);
        return EE_BASE + 13'(i * 4);
    endfunction : arr

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // a bus wait that runs past its bound ends the run
    task automatic tmo(input int n);
        if (n > 200)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: wait ran out", $time);
            end_of_test();
        end
    endtask : tmo

    // bready is raised only after bvalid is seen, so the slave must hold its answer
    task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            tmo(n);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [12:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            tmo(n);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        if (er === RESP_OKAY) chk(s_axi_rdata, {24'h0, d});
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : rd

    // setup, target write, voltage on, voltage off, clear
    task automatic op(input logic [7:0] ctl, input logic [12:0] a, input logic [7:0] d);
        wr(A_CTRL, ctl);
        wr(a, d);
        wr(A_CTRL, ctl | 8'h01);
        wr(A_CTRL, ctl);
        wr(A_CTRL, 8'h00);
        repeat (3) @(posedge aclk);
    endtask : op

    task automatic rst(input logic boot);
        aresetn <= 1'b0;
        bootstrap_mode <= boot;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : rst

    // ----------------
    // main sequence
    // ----------------
    initial
    begin
        rst(1'b0);
        rd(A_CTRL, PROG_CTRL_RST);
        rd(A_BP, BLK_PROT_RST);
        rd(A_BAD, 8'h00, RESP_DECERR);
        wr(A_BAD, 8'hff, RESP_DECERR);
        wr(A_CTRL, 8'hff);
        rd(A_CTRL, 8'hdf);
        wr(A_CTRL, 8'h00);
        wr(A_OPT, 8'h40);
        repeat (2) @(posedge aclk);
        chk(32'(internal_osc_select), 32'h1);
        wr(A_BP, 8'h00);
        op(8'h06, arr(300), 8'h00);
        rd(arr(0), ERASED);
        rd(arr(639), ERASED);
        op(8'hc2, arr(34), 8'h5a);
        rd(arr(2), 8'h5a);
        rd(arr(306), 8'h5a);
        rd(arr(322), ERASED);
        // program with scope bits set, then try to disturb it
        wr(A_CTRL, 8'h1a);
        wr(arr(3), 8'ha5);
        wr(arr(4), 8'h11);
        rd(arr(3), 8'h00);
        wr(A_CTRL, 8'h1b);
        repeat (2) @(posedge aclk);
        chk(32'(charge_pump_on), 32'h1);
        wr(arr(3), 8'h00);
        repeat (20) @(posedge aclk);
        chk(32'(charge_pump_on), 32'h1);
        wr(A_CTRL, 8'h00);
        repeat (3) @(posedge aclk);
        chk(32'(charge_pump_on), 32'h0);
        rd(arr(3), 8'ha5);
        rd(arr(4), ERASED);
        op(8'h0e, arr(20), 8'h00);
        rd(arr(18), ERASED);
        rd(arr(34), 8'h5a);
        op(8'h16, arr(3), 8'h00);
        rd(arr(3), ERASED);
        rd(arr(2), 8'h5a);
        wr(A_BP, 8'h01);
        op(8'h02, arr(0), 8'h00);
        rd(arr(0), ERASED);
        rd(arr(2), 8'h5a);
        wr(A_BP, 8'h00);
        // configuration: direct write in special mode, then through the cell
        special_mode_indicator <= 1'b1;
        wr(A_CFG, 8'h0b);
        rd(A_CFG, 8'h6b);
        repeat (2) @(posedge aclk);
        chk(32'(single_chip_only), 32'h0);
        special_mode_indicator <= 1'b0;
        op(8'h16, A_CFG, 8'h00);
        op(8'h02, A_CFG, 8'h01);
        rd(A_CFG, 8'h6b);
        rst(1'b0);
        rd(A_CFG, 8'h61);
        chk(32'(single_chip_only), 32'h1);
        // secured bootstrap wipes array, protection and configuration
        rst(1'b1);
        for (w = 0; w < 3000 && ram_fill_done !== 1'b1; w++) @(posedge aclk);
        if (w == 3000) tmo(999);
        repeat (20) @(posedge aclk);
        rd(A_BP, 8'h00);
        rd(arr(2), ERASED);
        rst(1'b0);
        rd(A_CFG, ERASED);
        end_of_test();
    end
endmodule : eepc_top_test

bind eepc_top eepc_props chk_u (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .special_mode_indicator, .ram_fill_done,
    .charge_pump_on, .system_config, .single_chip_only, .serial_ones_req, .ram_fill_req);
